// [rtl/crif_pkg.sv]
package crif_pkg;

	// register bus geometry
	localparam int CRIF_ADDR_W = 8;
	localparam int CRIF_DATA_W = 32;

	// the one register of this block
	localparam logic [CRIF_ADDR_W-1:0] CRIF_CLOCK_EVENT_INTERRUPT_OFS = 8'h08;
	localparam logic [CRIF_DATA_W-1:0] CRIF_CLOCK_EVENT_INTERRUPT_RST = 32'h0000_0000;

	// ready group: pll, ext fast, int fast, ext slow, int slow (msb to lsb)
	localparam int CRIF_READY_W = 5;

	// flag positions (read only)
	localparam int CRIF_READY_FLAG_LSB = 0;
	localparam int CRIF_PARITY_FLAG_BIT = 5;
	localparam int CRIF_CLOCK_FAIL_FLAG_BIT = 7;

	// enable positions (read/write)
	localparam int CRIF_READY_EN_LSB = 8;
	localparam int CRIF_PARITY_IRQ_EN_BIT = 13;
	localparam int CRIF_PARITY_RST_EN_BIT = 14;

	// clear positions (write only, read as zero)
	localparam int CRIF_READY_CLR_LSB = 16;
	localparam int CRIF_PARITY_CLR_BIT = 21;
	localparam int CRIF_CLOCK_FAIL_CLR_BIT = 23;
	localparam int CRIF_CLR_MSB = 23;

	// index of each source in the synchronised event vector
	localparam int CRIF_EV_READY_LSB = 0;
	localparam int CRIF_EV_CLOCK_FAIL = 5;
	localparam int CRIF_EV_PARITY = 6;
	localparam int CRIF_EV_W = 7;

endpackage : crif_pkg

// [rtl/crif_event_if.sv]
`timescale 1ns/1ps
`default_nettype none

// synchronised level and rising-edge pulse of each outside event
interface crif_event_if #(
	parameter int W = 7
);
	logic [W-1:0] level;
	logic [W-1:0] rise;

	modport src (output level, output rise);
	modport dst (input level, input rise);
endinterface : crif_event_if

`default_nettype wire

// [rtl/crif_sync_edge.sv]
`timescale 1ns/1ps
`default_nettype none

module crif_sync_edge #(
	parameter int W = 7
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [W-1:0] raw_in,
	crif_event_if.src ev
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;
	logic [W-1:0] prev_reg;

	// first stage: read only by the second stage
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_reg <= '0;
		end else begin
			meta_reg <= raw_in;
		end
	end

	// second stage gives a settled level
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sync_reg <= '0;
		end else begin
			sync_reg <= meta_reg;
		end
	end

	// delayed copy for edge detection
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prev_reg <= '0;
		end else begin
			prev_reg <= sync_reg;
		end
	end

	// a source held high sets its flag once, not again after every clear
	assign ev.level = sync_reg;
	assign ev.rise = sync_reg & ~prev_reg;

endmodule : crif_sync_edge

`default_nettype wire

// [rtl/crif_top.sv]
// Behaviour
// - Writing 1 to bit 23 clears the clock failure flag, writing 0 leaves it alone.
// - Writing 1 to bit 21 clears the parity error flag, writing 0 has no effect.
// - Writing 1 to bits 20 to 16 clears the matching ready flag (pll, ext fast, int fast, ext slow, int slow).
// - With bit 14 set a parity error raises a reset request, with it clear no reset is raised.
// - With bit 13 set a parity error produces an interrupt, with it clear it produces none.
// - Bits 12 to 8 are read/write ready interrupt enables in the same source order.
// - Bit 7 is set by a failure of the external fast oscillator, stays until cleared, and is read only.
// - Bit 5 is set by a parity error, reads 1 while set, and is cleared only by its clear bit.
// - Bit 4 is set only when the pll enable is 1 and the pll signals lock, and holds until cleared.
// - Bit 3 is set only when its enable is 1 and the external fast oscillator is ready.
// - Bit 2 is set only when its enable is 1 and the internal fast oscillator is ready.
// - Bit 1 is set only when its enable is 1 and the external slow oscillator is ready.
// - Bit 0 is set only when its enable is 1 and the internal slow oscillator is ready.
// - After reset every field reads zero and all enables are off.
`timescale 1ns/1ps
`default_nettype none

module crif_top
	import crif_pkg::*;
#(
	parameter int ADDR_W = CRIF_ADDR_W
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [CRIF_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [CRIF_DATA_W-1:0] reg_rdata,
	input wire logic pll_lock,
	input wire logic ext_fast_osc_ready,
	input wire logic int_fast_osc_ready,
	input wire logic ext_slow_osc_ready,
	input wire logic int_slow_osc_ready,
	input wire logic clock_fail,
	input wire logic parity_error,
	output logic irq,
	output logic parity_reset_req
);

	// the register offset must fit the address bus
	generate
		if (ADDR_W < CRIF_ADDR_W) begin : g_bad_addr_w
			$error("crif_top: ADDR_W too narrow for the register offset");
		end
	endgenerate

	// address decode, shared by read and write
	function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
		addr_hit = (a == ADDR_W'(CRIF_CLOCK_EVENT_INTERRUPT_OFS));
	endfunction : addr_hit

	crif_event_if #(.W(CRIF_EV_W)) ev ();

	logic [CRIF_EV_W-1:0] raw_events;

	// order matches the ready flag layout, pll at the top
	assign raw_events = {parity_error, clock_fail, pll_lock, ext_fast_osc_ready,
		int_fast_osc_ready, ext_slow_osc_ready, int_slow_osc_ready};

	// all sources come from other clocks or pins
	crif_sync_edge #(.W(CRIF_EV_W)) crif_sync_edge_inst (
		.clk(clk),
		.rstn(rstn),
		.raw_in(raw_events),
		.ev(ev)
	);

	logic wr_hit;
	logic rd_hit;
	logic [CRIF_READY_W-1:0] ready_en_reg;
	logic parity_irq_en_reg;
	logic parity_rst_en_reg;
	logic [CRIF_READY_W-1:0] ready_flag_reg;
	logic [CRIF_READY_W-1:0] ready_flag_next;
	logic [CRIF_READY_W-1:0] ready_set;
	logic [CRIF_READY_W-1:0] ready_clr;
	logic clock_fail_flag_reg;
	logic clock_fail_flag_next;
	logic clock_fail_set;
	logic clock_fail_clr;
	logic parity_flag_reg;
	logic parity_flag_next;
	logic parity_set;
	logic parity_clr;
	logic [CRIF_DATA_W-1:0] read_word;
	logic [CRIF_DATA_W-1:0] reg_rdata_reg;
	logic irq_reg;
	logic parity_reset_req_reg;

	// strobes only count at our own offset
	assign wr_hit = reg_wr && addr_hit(reg_addr);
	assign rd_hit = reg_rd && addr_hit(reg_addr);

	// hardware set terms; ready sources are gated by their enable
	assign ready_set = ev.rise[CRIF_EV_READY_LSB +: CRIF_READY_W] & ready_en_reg;
	assign clock_fail_set = ev.rise[CRIF_EV_CLOCK_FAIL];
	assign parity_set = ev.rise[CRIF_EV_PARITY];

	// clear pulses; reserved write bits are simply dropped
	assign ready_clr = wr_hit ? reg_wdata[CRIF_READY_CLR_LSB +: CRIF_READY_W] : '0;
	assign clock_fail_clr = wr_hit && reg_wdata[CRIF_CLOCK_FAIL_CLR_BIT];
	assign parity_clr = wr_hit && reg_wdata[CRIF_PARITY_CLR_BIT];

	// set is or-ed in last so an event in the clear cycle survives
	assign ready_flag_next = (ready_flag_reg & ~ready_clr) | ready_set;
	assign clock_fail_flag_next = (clock_fail_flag_reg && !clock_fail_clr) || clock_fail_set;
	assign parity_flag_next = (parity_flag_reg && !parity_clr) || parity_set;

	// software enables
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ready_en_reg <= CRIF_CLOCK_EVENT_INTERRUPT_RST[CRIF_READY_EN_LSB +: CRIF_READY_W];
			parity_irq_en_reg <= CRIF_CLOCK_EVENT_INTERRUPT_RST[CRIF_PARITY_IRQ_EN_BIT];
			parity_rst_en_reg <= CRIF_CLOCK_EVENT_INTERRUPT_RST[CRIF_PARITY_RST_EN_BIT];
		end else if (wr_hit) begin
			ready_en_reg <= reg_wdata[CRIF_READY_EN_LSB +: CRIF_READY_W];
			parity_irq_en_reg <= reg_wdata[CRIF_PARITY_IRQ_EN_BIT];
			parity_rst_en_reg <= reg_wdata[CRIF_PARITY_RST_EN_BIT];
		end
	end

	// sticky ready flags
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ready_flag_reg <= CRIF_CLOCK_EVENT_INTERRUPT_RST[CRIF_READY_FLAG_LSB +: CRIF_READY_W];
		end else begin
			ready_flag_reg <= ready_flag_next;
		end
	end

	// sticky clock failure flag
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			clock_fail_flag_reg <= CRIF_CLOCK_EVENT_INTERRUPT_RST[CRIF_CLOCK_FAIL_FLAG_BIT];
		end else begin
			clock_fail_flag_reg <= clock_fail_flag_next;
		end
	end

	// sticky parity flag, set regardless of the irq enable
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			parity_flag_reg <= CRIF_CLOCK_EVENT_INTERRUPT_RST[CRIF_PARITY_FLAG_BIT];
		end else begin
			parity_flag_reg <= parity_flag_next;
		end
	end

	// read view; clear bits and reserved bits read zero
	always_comb begin
		read_word = '0;
		read_word[CRIF_READY_FLAG_LSB +: CRIF_READY_W] = ready_flag_reg;
		read_word[CRIF_PARITY_FLAG_BIT] = parity_flag_reg;
		read_word[CRIF_CLOCK_FAIL_FLAG_BIT] = clock_fail_flag_reg;
		read_word[CRIF_READY_EN_LSB +: CRIF_READY_W] = ready_en_reg;
		read_word[CRIF_PARITY_IRQ_EN_BIT] = parity_irq_en_reg;
		read_word[CRIF_PARITY_RST_EN_BIT] = parity_rst_en_reg;
	end

	// read data valid only in the cycle after the strobe, zero elsewhere
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata_reg <= '0;
		end else begin
			reg_rdata_reg <= rd_hit ? read_word : '0;
		end
	end

	// registered interrupt level, one cycle behind the flags
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= (|ready_flag_reg) || clock_fail_flag_reg
				|| (parity_flag_reg && parity_irq_en_reg);
		end
	end

	// reset request is a one-cycle pulse per detected error
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			parity_reset_req_reg <= 1'b0;
		end else begin
			parity_reset_req_reg <= parity_rst_en_reg && parity_set;
		end
	end

	assign reg_rdata = reg_rdata_reg;
	assign irq = irq_reg;
	assign parity_reset_req = parity_reset_req_reg;

	// checks on the block's own state
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence seq_fail_clear;
		wr_hit && reg_wdata[CRIF_CLOCK_FAIL_CLR_BIT];
	endsequence

	sequence seq_fail_quiet;
		!ev.rise[CRIF_EV_CLOCK_FAIL];
	endsequence

	sequence seq_parity_clear;
		wr_hit && reg_wdata[CRIF_PARITY_CLR_BIT] && !ev.rise[CRIF_EV_PARITY];
	endsequence

	sequence seq_parity_only;
		parity_flag_reg && parity_irq_en_reg;
	endsequence

	sequence seq_read_req;
		rd_hit;
	endsequence

	sequence seq_parity_reset_armed;
		parity_rst_en_reg && ev.rise[CRIF_EV_PARITY];
	endsequence

	sequence seq_reset_pulse;
		parity_reset_req ##1 !parity_reset_req;
	endsequence

	// clock failure flag: clear, hold and set
	chk_fail_clear_one: assert property (seq_fail_clear and seq_fail_quiet |=> !clock_fail_flag_reg)
		else $error("clock failure flag not cleared");

	chk_fail_sticky_hold: assert property (clock_fail_flag_reg
		&& !(wr_hit && reg_wdata[CRIF_CLOCK_FAIL_CLR_BIT])
		|=> clock_fail_flag_reg)
		else $error("clock failure flag dropped without clear");

	chk_fail_set_event: assert property (ev.rise[CRIF_EV_CLOCK_FAIL] |=> clock_fail_flag_reg
		##1 irq)
		else $error("clock failure did not set flag and irq");

	// parity flag: clear, hold and set
	chk_parity_clear_one: assert property (seq_parity_clear |=> !parity_flag_reg)
		else $error("parity flag not cleared");

	chk_parity_flag_hold: assert property (parity_flag_reg && !(wr_hit && reg_wdata[CRIF_PARITY_CLR_BIT])
		|=> parity_flag_reg)
		else $error("parity flag dropped without clear");

	chk_parity_set_event: assert property (ev.rise[CRIF_EV_PARITY] |=> parity_flag_reg)
		else $error("parity error did not set flag");

	// ready flags and reset request
	chk_ready_clear_bits: assert property (wr_hit && ready_set == '0
		|=> (ready_flag_reg & $past(ready_clr)) == '0)
		else $error("ready flag survived its clear");

	chk_ready_set_gate: assert property (((ready_flag_reg & ~$past(ready_flag_reg))
		& ~$past(ev.rise[CRIF_EV_READY_LSB +: CRIF_READY_W] & ready_en_reg)) == '0)
		else $error("ready flag set without enabled ready edge");

	chk_ready_flag_hold: assert property (ready_clr == '0
		|=> (($past(ready_flag_reg) & ~ready_flag_reg) == '0))
		else $error("ready flag dropped without clear");

	chk_set_beats_clear: assert property (wr_hit && ((ready_clr & ready_set) != '0)
		|=> (ready_flag_reg & $past(ready_set)) == $past(ready_set))
		else $error("same-cycle clear beat a ready set");

	chk_reset_req_gate: assert property (parity_reset_req |-> $past(parity_rst_en_reg)
		&& $past(ev.rise[CRIF_EV_PARITY]))
		else $error("reset request without enabled parity error");

	chk_reset_req_fire: assert property (seq_parity_reset_armed |=> seq_reset_pulse)
		else $error("reset request not a single pulse");

	// interrupt level and read port
	chk_parity_irq_on: assert property (seq_parity_only |=> irq)
		else $error("enabled parity flag gave no irq");

	chk_irq_cause_only: assert property (irq |-> $past((|ready_flag_reg) || clock_fail_flag_reg
		|| (parity_flag_reg && parity_irq_en_reg)))
		else $error("irq without an active cause");

	chk_enable_write_back: assert property (wr_hit ##1 seq_read_req |=> reg_rdata[CRIF_CLR_MSB:CRIF_READY_EN_LSB]
		== {{(CRIF_CLR_MSB-CRIF_PARITY_RST_EN_BIT){1'b0}}, $past(reg_wdata[CRIF_PARITY_RST_EN_BIT:CRIF_READY_EN_LSB], 2)})
		else $error("enable readback mismatch or clear bits nonzero");

	chk_read_one_cycle: assert property (!rd_hit |=> reg_rdata == '0)
		else $error("read data outside its cycle");

	chk_reset_all_zero: assert property (disable iff (1'b0) $rose(rstn) |-> reg_rdata == '0 && !irq
		&& !parity_reset_req && ready_en_reg == '0 && ready_flag_reg == '0
		&& !clock_fail_flag_reg && !parity_flag_reg && !parity_irq_en_reg && !parity_rst_en_reg)
		else $error("state not zero after reset");

	// further checks; each names the flop it watches so a broken term shows up
	chk_fail_zero_write: assert property (clock_fail_flag_reg && wr_hit
		&& !reg_wdata[CRIF_CLOCK_FAIL_CLR_BIT] |=> clock_fail_flag_reg)
		else $error("clock failure flag lost on a zero clear bit");

	chk_parity_zero_write: assert property (parity_flag_reg && wr_hit
		&& !reg_wdata[CRIF_PARITY_CLR_BIT] |=> parity_flag_reg)
		else $error("parity flag lost on a zero clear bit");

	chk_reset_req_off: assert property (!parity_rst_en_reg |=> !parity_reset_req)
		else $error("reset request while disabled");

	chk_reset_req_flag: assert property (parity_reset_req |-> parity_flag_reg)
		else $error("reset request without parity flag");

	chk_parity_irq_off: assert property (parity_flag_reg && !parity_irq_en_reg
		&& ready_flag_reg == '0 && !clock_fail_flag_reg |=> !irq)
		else $error("disabled parity flag raised irq");

	chk_ready_irq_on: assert property (ready_flag_reg != '0 || clock_fail_flag_reg |=> irq)
		else $error("ready or clock failure flag gave no irq");

	chk_enable_hold: assert property (!wr_hit |=> $stable(ready_en_reg)
		&& $stable(parity_irq_en_reg) && $stable(parity_rst_en_reg))
		else $error("enable changed without a write");

	chk_ready_set_event: assert property (
		(ev.rise[CRIF_EV_READY_LSB +: CRIF_READY_W] & ready_en_reg) != '0
		|=> (ready_flag_reg & $past(ready_set)) == $past(ready_set))
		else $error("enabled ready edge did not set its flag");

	chk_read_flag_view: assert property (rd_hit
		|=> reg_rdata[CRIF_CLOCK_FAIL_FLAG_BIT:CRIF_READY_FLAG_LSB] == {$past(clock_fail_flag_reg),
		1'b0, $past(parity_flag_reg), $past(ready_flag_reg)})
		else $error("flag readback mismatch");

	chk_rise_from_low: assert property ((ev.rise & ~(ev.level & ~$past(ev.level))) == '0)
		else $error("event edge without a low to high step");

	chk_clear_bits_zero: assert property (rd_hit
		|=> reg_rdata[CRIF_CLR_MSB:CRIF_READY_CLR_LSB] == '0
		&& reg_rdata[CRIF_DATA_W-1:CRIF_CLR_MSB+1] == '0)
		else $error("clear or reserved bits read nonzero");

	chk_miss_ignored: assert property (reg_wr && !addr_hit(reg_addr) |=> $stable(ready_en_reg)
		&& $stable(parity_irq_en_reg) && $stable(parity_rst_en_reg))
		else $error("write to another offset changed an enable");

	chk_rdata_miss_zero: assert property (reg_rd && !addr_hit(reg_addr) |=> reg_rdata == '0)
		else $error("read at another offset returned data");

endmodule : crif_top

`default_nettype wire

// [test/crif_src_model.sv]
`timescale 1ns/1ps
`default_nettype none

// far side: clock sources, monitor and ram checker as event levels
module crif_src_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [6:0] req,
	input wire logic [2:0] hold_len,
	output logic [6:0] lvl
);
	logic [2:0] cnt_reg;

	// a line stays high hold_len cycles, so prompt and slow sources both occur
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lvl <= 7'h00;
			cnt_reg <= 3'h0;
		end else if (req != 7'h00) begin
			lvl <= req;
			cnt_reg <= hold_len;
		end else if (cnt_reg > 3'h1) begin
			cnt_reg <= cnt_reg - 3'h1;
		end else begin
			lvl <= 7'h00; // low again, so the next event is a fresh rise
		end
	end
endmodule : crif_src_model

`default_nettype wire

// [test/crif_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module crif_tb_top;
	import crif_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic irq;
	logic parity_reset_req;
	logic [6:0] ev_req = 7'h00;
	logic [2:0] hold_len = 3'h1;
	logic [6:0] lvl;
	logic rd_pend = 1'b0;
	logic [31:0] exp_q[$];
	logic [31:0] en;
	int seed = 32'hf5c0b9e7;
	int n_mismatch = 0;
	int n_tests = 0;
	int rst_cnt = 0;
	int c0;

	crif_top crif_top_inst (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pll_lock(lvl[4]),
		.ext_fast_osc_ready(lvl[3]), .int_fast_osc_ready(lvl[2]), .ext_slow_osc_ready(lvl[1]),
		.int_slow_osc_ready(lvl[0]), .clock_fail(lvl[5]), .parity_error(lvl[6]), .irq(irq),
		.parity_reset_req(parity_reset_req));

	crif_src_model crif_src_model_inst (.clk(clk), .rstn(rstn), .req(ev_req),
		.hold_len(hold_len), .lvl(lvl));

	// 25 mhz clock
	always #20 clk = ~clk;

	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: read %h, expected %h", $time, got, exp);
		end
	endtask : cmp32

	task automatic cmp1(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: output %b, expected %b", $time, got, exp);
		end
	endtask : cmp1

	task automatic results;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : results

	// reserved bits are only ever written as zero by these callers
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		exp_q.push_back(exp);
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk); // outputs settled for the caller's checks
	endtask : rd

	// write then read with no gap between the strobes
	task automatic wr_rd(input logic [31:0] d, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= 8'h08;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		exp_q.push_back(exp);
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask : wr_rd

	// the synced edge lands in the very cycle of the clear write
	task automatic ev_clr(input logic [6:0] v, input logic [31:0] d);
		@(posedge clk);
		ev_req <= v;
		hold_len <= 3'h1;
		@(posedge clk);
		ev_req <= 7'h00;
		@(posedge clk);
		@(posedge clk);
		reg_addr <= 8'h08;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		repeat (8) @(posedge clk);
	endtask : ev_clr

	// one event; the wait covers the sync chain and the longest hold
	task automatic ev(input logic [6:0] v);
		@(posedge clk);
		ev_req <= v;
		hold_len <= 3'($unsigned($random(seed)) % 6 + 1);
		@(posedge clk);
		ev_req <= 7'h00;
		repeat (12) @(posedge clk);
	endtask : ev

	task automatic do_reset;
		rstn <= 1'b0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
	endtask : do_reset

	// read data stand only in the cycle after the strobe
	always @(posedge clk) rd_pend <= reg_rd;
	always @(negedge clk) begin
		if (rd_pend) begin
			if (exp_q.size() == 0) begin
				n_mismatch++;
				$display("Error at %0t: unexpected read data", $time);
			end else begin
				cmp32(reg_rdata, exp_q.pop_front());
			end
		end
	end

	// count reset request pulses
	always @(posedge clk) if (parity_reset_req === 1'b1) rst_cnt++;

	// watchdog well past the expected few hundred cycles
	initial begin
		#800000;
		n_mismatch++;
		$display("Error at %0t: timeout", $time);
		results();
	end

	initial begin
		do_reset();
		rd(8'h08, 32'h0);
		wr(8'h04, 32'h0000_7f00);
		rd(8'h04, 32'h0);
		rd(8'h08, 32'h0);
		en = $random(seed) & 32'h0000_7f00;
		wr_rd(en | 32'h00bf_0000, en);
		wr(8'h08, 32'h0);
		$display("test registers done");
		for (int i = 0; i < 5; i++) begin
			ev(7'(1 << i));
			rd(8'h08, 32'h0);
			cmp1(irq, 1'b0);
			wr(8'h08, 32'h100 << i);
			ev(7'(1 << i));
			rd(8'h08, (32'h100 << i) | (32'h1 << i));
			cmp1(irq, 1'b1);
			wr(8'h08, 32'h0);
			rd(8'h08, 32'h1 << i);
			wr(8'h08, 32'h1_0000 << i);
			rd(8'h08, 32'h0);
			cmp1(irq, 1'b0);
		end
		wr(8'h08, 32'h100);
		ev_clr(7'h21, 32'h0081_0100);
		rd(8'h08, 32'h0000_0181);
		cmp1(irq, 1'b1);
		wr(8'h08, 32'h0081_0000);
		rd(8'h08, 32'h0);
		$display("test ready flags done");
		wr(8'h08, 32'h80);
		rd(8'h08, 32'h0);
		ev(7'h20);
		rd(8'h08, 32'h80);
		cmp1(irq, 1'b1);
		wr(8'h08, 32'h0);
		rd(8'h08, 32'h80);
		wr(8'h08, 32'h0080_0000);
		rd(8'h08, 32'h0);
		cmp1(irq, 1'b0);
		$display("test clock fail done");
		c0 = rst_cnt;
		ev(7'h40);
		rd(8'h08, 32'h20);
		cmp1(irq, 1'b0);
		cmp1(rst_cnt == c0, 1'b1);
		wr(8'h08, 32'h2000);
		rd(8'h08, 32'h2020);
		cmp1(irq, 1'b1);
		wr(8'h08, 32'h6000);
		ev(7'h40);
		cmp1(rst_cnt == c0 + 1, 1'b1);
		wr(8'h08, 32'h0020_6000);
		rd(8'h08, 32'h6000);
		cmp1(irq, 1'b0);
		$display("test parity done");
		ev(7'h20);
		rd(8'h08, 32'h0000_6080);
		cmp1(irq, 1'b1);
		@(posedge clk);
		do_reset();
		rd(8'h08, 32'h0);
		cmp1(irq, 1'b0);
		$display("test second reset done");
		repeat (3) @(posedge clk);
		results();
	end
endmodule : crif_tb_top

`default_nettype wire
